// ==== rcl_pkg.sv ====
// Constants and types for the reset, strap capture and EEPROM loader block
package rcl_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int QUIESCE_NS    = 415;
	localparam int POR_US        = 415;
	localparam int LOAD_MAX_US   = 320;
	localparam int QUIESCE_CYC   = (QUIESCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_CYC       = (POR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_MAX_CYC  = (LOAD_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int SK_HALF_CYC   = 10;
	// Register offsets
	localparam logic [7:0] ADDR_CFG_A  = 8'h00;
	localparam logic [7:0] ADDR_CFG_B  = 8'h01;
	localparam logic [7:0] ADDR_CFG_C  = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_PROM   = 8'h10;
	// Field positions and reset values
	localparam int CFGA_IOMODE_BIT  = 7;
	localparam int CFGB_LINKDIS_BIT = 5;
	localparam int CFGB_STOREGO_BIT = 4;
	localparam logic [7:0] CFG_A_RST = 8'h00;
	localparam logic [7:0] CFG_B_RST = 8'h00;
	localparam logic [7:0] CFG_C_RST = 8'h00;
	// Serial EEPROM: 16 words of 16 bits
	localparam int EE_WORDS  = 16;
	localparam int EE_ADDR_W = 6;
	localparam int DATA_W    = 16;
	localparam int CMD_W     = 1 + 2 + EE_ADDR_W + DATA_W;
	localparam logic [4:0] SHORT_LEN = 5'(1 + 2 + EE_ADDR_W);
	localparam logic [4:0] LONG_LEN  = 5'(CMD_W);
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_MISC  = 2'h0;
	localparam logic [EE_ADDR_W-1:0] EWEN_ADDR      = 6'h30;
	localparam logic [EE_ADDR_W-1:0] EWDS_ADDR      = 6'h00;
	localparam logic [EE_ADDR_W-1:0] EE_CFG_WORD    = 6'(EE_WORDS - 2);
	localparam logic [EE_ADDR_W-1:0] EE_TOP_WORD    = 6'(EE_WORDS - 1);
	localparam logic [EE_ADDR_W-1:0] EE_WIDE_WORD   = 6'h07;
	localparam logic [EE_ADDR_W-1:0] EE_NARROW_WORD = 6'h08;
	localparam logic [7:0] TOP_BYTE_MARK = 8'h73;
	localparam int PROM_WORDS = 8;
	localparam int SHM_WORDS  = 4;
	localparam int IOM_WORDS  = 7;
	// State machines
	typedef enum logic [4:0] {
		ENG_IDLE  = 5'h01,
		ENG_SHIFT = 5'h02,
		ENG_READ  = 5'h04,
		ENG_GAP   = 5'h08,
		ENG_BUSY  = 5'h10
	} rcl_eng_t;
	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'h1,
		SEQ_LOAD  = 3'h2,
		SEQ_STORE = 3'h4
	} rcl_seq_t;
endpackage

// ==== rcl_reset_config_loader.sv ====
// Reset qualification, strap capture and serial EEPROM loader
module rcl_reset_config_loader
	import rcl_pkg::*;
#(
	parameter int POR_CYCLES  = POR_CYC,
	parameter int LOAD_CYCLES = LOAD_MAX_CYC,
	parameter int SK_HALF     = SK_HALF_CYC
) (
	// Clock and device reset
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	// Host reset and strap pins
	input  wire logic        hostReset,
	input  wire logic [23:0] strapIn,
	input  wire logic        eepromConfigSelect,
	input  wire logic        busWidthStrap,
	output logic             strapPullDown,
	// Internal status
	output logic             outputQuiesce,
	output logic             configCaptureWindow,
	output logic             accessBlocked,
	output logic             linkTestDisable,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [7:0]       regRdData,
	// Serial EEPROM
	output logic             eeCs,
	output logic             eeSk,
	output logic             eeDi,
	input  wire logic        eeDo
);
	localparam int CW = $clog2(POR_CYCLES + 1);

	function automatic logic [CMD_W-1:0] cmdWord(input logic [1:0] op, input logic [EE_ADDR_W-1:0] addr,
			input logic [DATA_W-1:0] data);
		cmdWord = {1'b1, op, addr, data};
	endfunction

	function automatic logic [EE_ADDR_W-1:0] loadAddr(input logic [3:0] step, input logic [3:0] cfgN,
			input logic io, input logic wide);
		logic [3:0] p;
		p = step - cfgN;
		if (step < cfgN) begin
			loadAddr = EE_CFG_WORD + EE_ADDR_W'(step);
		end else if (io && p == 4'(IOM_WORDS)) begin
			loadAddr = wide ? EE_WIDE_WORD : EE_NARROW_WORD;
		end else begin
			loadAddr = EE_ADDR_W'(p);
		end
	endfunction

	logic [CW-1:0]    hostCnt_q;
	logic             hostPrev_q;
	logic             resetFell;
	logic             loadReq_q;
	logic             cfgSel_q;
	logic             wide_q;
	logic [7:0]       cfgA_q;
	logic [7:0]       cfgB_q;
	logic [7:0]       cfgC_q;
	logic [15:0]      promStore_q [PROM_WORDS];
	logic [7:0]       divCnt_q;
	logic             tick;
	rcl_eng_t         engState_q;
	logic [CMD_W-1:0] cmdSr_q;
	logic [4:0]       bitCnt_q;
	logic [4:0]       rxCnt_q;
	logic [15:0]      rxSr_q;
	logic             engRead_q;
	logic             engWait_q;
	logic             engDone_q;
	logic             engKick;
	logic             engAccept;
	logic [CMD_W-1:0] kickCmd;
	logic [4:0]       kickLen;
	logic             kickRead;
	logic             kickWait;
	rcl_seq_t         seqState_q;
	logic [3:0]       step_q;
	logic             waitEng_q;
	logic [3:0]       cfgN;
	logic [3:0]       loadTotal;
	logic [3:0]       promIdx;
	logic             hostWr;
	logic             cfgBWrite;
	logic [1:0]       storeCnt_q;
	logic             storeGo_q;
	logic             storeStart_q;
	logic [7:0]       stashA_q;
	logic [7:0]       stashB_q;
	logic [7:0]       stashC_q;
	logic [15:0]      loadCnt_q;

	// Host reset timing
	assign resetFell = hostPrev_q && !hostReset;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hostCnt_q  <= '0;
			hostPrev_q <= 1'b0;
		end else begin
			hostPrev_q <= hostReset;
			if (!hostReset) begin
				hostCnt_q <= '0;
			end else if (hostCnt_q != CW'(POR_CYCLES)) begin
				hostCnt_q <= hostCnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			outputQuiesce <= 1'b0;
		end else begin
			outputQuiesce <= hostReset && (hostCnt_q >= CW'(QUIESCE_CYC - 1));
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			configCaptureWindow <= 1'b0;
		end else if (!hostReset) begin
			configCaptureWindow <= 1'b0;
		end else if (hostCnt_q >= CW'(POR_CYCLES - 1)) begin
			configCaptureWindow <= 1'b1;
		end
	end

	assign strapPullDown = outputQuiesce || configCaptureWindow;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			loadReq_q <= 1'b0;
			cfgSel_q  <= 1'b0;
			wide_q    <= 1'b0;
		end else if (resetFell && configCaptureWindow) begin
			loadReq_q <= 1'b1;
			cfgSel_q  <= eepromConfigSelect;
			wide_q    <= busWidthStrap;
		end else if (seqState_q == SEQ_IDLE && !outputQuiesce) begin
			loadReq_q <= 1'b0;
		end
	end

	// Serial clock divider
	assign tick = (divCnt_q == 8'(SK_HALF - 1));

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= 8'h00;
		end else begin
			divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
		end
	end

	assign engAccept = engKick && tick && (engState_q == ENG_IDLE);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			engState_q <= ENG_IDLE;
			cmdSr_q    <= '0;
			bitCnt_q   <= 5'h00;
			rxCnt_q    <= 5'h00;
			rxSr_q     <= 16'h0000;
			engRead_q  <= 1'b0;
			engWait_q  <= 1'b0;
			engDone_q  <= 1'b0;
			eeCs       <= 1'b0;
			eeSk       <= 1'b0;
			eeDi       <= 1'b0;
		end else if (outputQuiesce) begin
			engState_q <= ENG_IDLE;
			engDone_q  <= 1'b0;
			eeCs       <= 1'b0;
			eeSk       <= 1'b0;
			eeDi       <= 1'b0;
		end else begin
			engDone_q <= 1'b0;
			case (engState_q)
				ENG_IDLE: begin
					if (engAccept) begin
						cmdSr_q    <= kickCmd;
						bitCnt_q   <= kickLen;
						engRead_q  <= kickRead;
						engWait_q  <= kickWait;
						eeCs       <= 1'b1;
						eeDi       <= kickCmd[CMD_W-1];
						engState_q <= ENG_SHIFT;
					end
				end
				ENG_SHIFT: begin
					if (tick && !eeSk) begin
						eeSk <= 1'b1;
					end else if (tick) begin
						eeSk <= 1'b0;
						if (bitCnt_q == 5'h01) begin
							eeDi       <= 1'b0;
							rxCnt_q    <= 5'(DATA_W);
							engState_q <= engRead_q ? ENG_READ : ENG_GAP;
						end else begin
							cmdSr_q  <= {cmdSr_q[CMD_W-2:0], 1'b0};
							eeDi     <= cmdSr_q[CMD_W-2];
							bitCnt_q <= bitCnt_q - 5'h01;
						end
					end
				end
				ENG_READ: begin
					if (tick && !eeSk) begin
						eeSk <= 1'b1;
					end else if (tick) begin
						eeSk    <= 1'b0;
						rxSr_q  <= {rxSr_q[14:0], eeDo};
						rxCnt_q <= rxCnt_q - 5'h01;
						if (rxCnt_q == 5'h01) begin
							engState_q <= ENG_GAP;
						end
					end
				end
				ENG_GAP: begin
					if (tick) begin
						eeCs       <= 1'b0;
						engDone_q  <= !engWait_q;
						engState_q <= engWait_q ? ENG_BUSY : ENG_IDLE;
					end
				end
				ENG_BUSY: begin
					// Ready shows as data-out high while selected
					if (tick && !eeCs) begin
						eeCs <= 1'b1;
					end else if (tick && eeDo) begin
						eeCs       <= 1'b0;
						engDone_q  <= 1'b1;
						engState_q <= ENG_IDLE;
					end
				end
				default: begin
					engState_q <= ENG_IDLE;
				end
			endcase
		end
	end

	assign cfgN = cfgSel_q ? 4'h2 : 4'h0;
	// I/O mode word count plus appended word
	assign loadTotal = cfgN + (cfgA_q[CFGA_IOMODE_BIT] ? 4'(IOM_WORDS + 1) : 4'(SHM_WORDS));
	assign promIdx = step_q - cfgN;
	assign engKick = (seqState_q != SEQ_IDLE) && !waitEng_q;

	always_comb begin
		kickCmd  = cmdWord(OP_READ, loadAddr(step_q, cfgN, cfgA_q[CFGA_IOMODE_BIT], wide_q), 16'h0000);
		kickLen  = SHORT_LEN;
		kickRead = 1'b1;
		kickWait = 1'b0;
		if (seqState_q == SEQ_STORE) begin
			kickRead = 1'b0;
			case (step_q)
				4'h0: begin
					kickCmd = cmdWord(OP_MISC, EWEN_ADDR, 16'h0000);
				end
				4'h1: begin
					kickCmd  = cmdWord(OP_WRITE, EE_CFG_WORD, {stashB_q, stashA_q});
					kickLen  = LONG_LEN;
					kickWait = 1'b1;
				end
				4'h2: begin
					kickCmd  = cmdWord(OP_WRITE, EE_TOP_WORD, {TOP_BYTE_MARK, stashC_q});
					kickLen  = LONG_LEN;
					kickWait = 1'b1;
				end
				default: begin
					kickCmd = cmdWord(OP_MISC, EWDS_ADDR, 16'h0000);
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seqState_q <= SEQ_IDLE;
			step_q     <= 4'h0;
			waitEng_q  <= 1'b0;
		end else if (outputQuiesce) begin
			seqState_q <= SEQ_IDLE;
			step_q     <= 4'h0;
			waitEng_q  <= 1'b0;
		end else begin
			case (seqState_q)
				SEQ_IDLE: begin
					step_q <= 4'h0;
					// load once the window has closed
					if (loadReq_q && !configCaptureWindow) begin
						seqState_q <= SEQ_LOAD;
					end else if (storeStart_q) begin
						seqState_q <= SEQ_STORE;
					end
				end
				SEQ_LOAD, SEQ_STORE: begin
					if (engAccept) begin
						waitEng_q <= 1'b1;
					end else if (engDone_q) begin
						waitEng_q <= 1'b0;
						step_q    <= step_q + 4'h1;
						if ((seqState_q == SEQ_LOAD && step_q == loadTotal - 4'h1) ||
								(seqState_q == SEQ_STORE && step_q == 4'h3)) begin
							seqState_q <= SEQ_IDLE;
						end
					end
				end
				default: begin
					seqState_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	assign accessBlocked = outputQuiesce || loadReq_q || (seqState_q == SEQ_LOAD);
	assign hostWr = regWr && !accessBlocked;
	assign cfgBWrite = hostWr && (regAddr == ADDR_CFG_B) && !storeGo_q;
	assign linkTestDisable = cfgB_q[CFGB_LINKDIS_BIT];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfgA_q <= CFG_A_RST;
			cfgB_q <= CFG_B_RST;
			cfgC_q <= CFG_C_RST;
		end else if (resetFell && configCaptureWindow) begin
			cfgA_q <= strapIn[7:0];
			cfgB_q <= strapIn[15:8];
			cfgC_q <= strapIn[23:16];
		end else if (seqState_q == SEQ_LOAD && engDone_q && step_q < cfgN) begin
			// A and B in lower word, C in top low byte
			if (step_q == 4'h0) begin
				cfgA_q <= rxSr_q[7:0];
				cfgB_q <= rxSr_q[15:8] & ~(8'h01 << CFGB_STOREGO_BIT);
			end else begin
				cfgC_q <= rxSr_q[7:0];
			end
		end else if (hostWr && regAddr == ADDR_CFG_A) begin
			cfgA_q <= regWrData;
		end else if (cfgBWrite && storeCnt_q == 2'h0) begin
			cfgB_q <= regWrData & ~(8'h01 << CFGB_STOREGO_BIT);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < PROM_WORDS; i++) begin
				promStore_q[i] <= 16'h0000;
			end
		end else if (seqState_q == SEQ_LOAD && engDone_q && step_q >= cfgN) begin
			promStore_q[promIdx[2:0]] <= rxSr_q;
		end
	end

	// Write-back collection
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			storeCnt_q   <= 2'h0;
			storeGo_q    <= 1'b0;
			storeStart_q <= 1'b0;
			stashA_q     <= 8'h00;
			stashB_q     <= 8'h00;
			stashC_q     <= 8'h00;
		end else if (outputQuiesce) begin
			storeCnt_q   <= 2'h0;
			storeGo_q    <= 1'b0;
			storeStart_q <= 1'b0;
		end else begin
			storeStart_q <= 1'b0;
			if (cfgBWrite && regWrData[CFGB_STOREGO_BIT]) begin
				// first of three values is B
				storeCnt_q <= 2'h1;
				storeGo_q  <= 1'b1;
				stashB_q   <= regWrData & ~(8'h01 << CFGB_STOREGO_BIT);
			end else if (hostWr && regAddr == ADDR_CFG_B && storeCnt_q != 2'h0) begin
				// next writes give A then C
				if (storeCnt_q == 2'h1) begin
					stashA_q   <= regWrData;
					storeCnt_q <= 2'h2;
				end else begin
					stashC_q     <= regWrData;
					storeCnt_q   <= 2'h0;
					storeStart_q <= 1'b1;
				end
			end else if (seqState_q == SEQ_STORE && engDone_q && step_q == 4'h3) begin
				storeGo_q <= 1'b0;
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= 8'h00;
		end else begin
			regRdData <= 8'h00;
			if (regRd && !accessBlocked) begin
				if (regAddr == ADDR_CFG_A) begin
					regRdData <= cfgA_q;
				end else if (regAddr == ADDR_CFG_B) begin
					regRdData <= cfgB_q | (8'(storeGo_q) << CFGB_STOREGO_BIT);
				end else if (regAddr == ADDR_CFG_C) begin
					regRdData <= cfgC_q;
				end else if (regAddr == ADDR_STATUS) begin
					regRdData <= {5'h00, wide_q, cfgSel_q, storeGo_q};
				end else if (regAddr[7:4] == ADDR_PROM[7:4]) begin
					regRdData <= regAddr[0] ? promStore_q[regAddr[3:1]][15:8] : promStore_q[regAddr[3:1]][7:0];
				end
			end
		end
	end

	// Load duration monitor
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			loadCnt_q <= 16'h0000;
		end else if (seqState_q != SEQ_LOAD) begin
			loadCnt_q <= 16'h0000;
		end else if (loadCnt_q != 16'hffff) begin
			loadCnt_q <= loadCnt_q + 16'h0001;
		end
	end

	// Consecutive host reset samples, kept apart from the timer for the quiesce check
	logic [3:0] hostRun_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hostRun_q <= 4'h0;
		end else if (!hostReset) begin
			hostRun_q <= 4'h0;
		end else if (hostRun_q != 4'hf) begin
			hostRun_q <= hostRun_q + 4'h1;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_QUIESCE_AFTER_HOLD: assert property (
		hostReset && hostRun_q >= 4'(QUIESCE_CYC - 1) |=> outputQuiesce)
		else $error("quiesce missing after nine reset cycles");
	AST_SHORT_PULSE_IGNORED: assert property (
		!hostReset ##1 hostReset [*8] ##1 !hostReset |-> !outputQuiesce)
		else $error("short reset raised quiesce");
	AST_WINDOW_NEEDS_LONG_RESET: assert property (
		$rose(configCaptureWindow) |-> $past(hostReset) && $past(hostCnt_q) >= CW'(POR_CYCLES - 1))
		else $error("capture window opened early");
	AST_STRAP_CAPTURE: assert property (
		resetFell && configCaptureWindow |=> cfgA_q == $past(strapIn[7:0]) && cfgC_q == $past(strapIn[23:16]))
		else $error("straps not captured at release");
	AST_PULLDOWN_HELD: assert property (
		configCaptureWindow || outputQuiesce |-> strapPullDown)
		else $error("pull-down dropped early");
	AST_LOAD_FOLLOWS_POR: assert property (
		resetFell && configCaptureWindow |-> ##2 seqState_q == SEQ_LOAD)
		else $error("load did not start after power-on reset");
	AST_BLOCKED_READ_ZERO: assert property (
		regRd && seqState_q == SEQ_LOAD |=> regRdData == 8'h00)
		else $error("read answered during load");
	AST_LOAD_TIME: assert property (
		loadCnt_q <= 16'(LOAD_CYCLES))
		else $error("address store load too long");
	AST_STORE_GO_READS: assert property (
		regRd && regAddr == ADDR_CFG_B && !accessBlocked |=> regRdData[CFGB_STOREGO_BIT] == $past(storeGo_q))
		else $error("store-go bit not visible");
	AST_CS_IDLE_CLOCK: assert property (
		!eeCs |-> !eeSk)
		else $error("serial clock active while deselected");
endmodule

// ==== rcl_eeprom_model.sv ====
// Behavioural serial EEPROM of sixteen 16-bit words
module rcl_eeprom_model
	import rcl_pkg::*;
(
	// Clock and write busy time
	input  wire logic ref_clk,
	input  wire logic [31:0] busyLen,
	// Serial link
	input  wire logic eeCs,
	input  wire logic eeSk,
	input  wire logic eeDi,
	output logic      eeDo
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] mem [EE_WORDS];
	logic [24:0]       sr;
	logic [5:0]        rdAddr;
	int                cnt     = 0;
	logic              wrEn    = 1'b0;
	logic              busy    = 1'b0;
	logic              reading = 1'b0;
	logic              drv     = 1'b0;
	logic              rel     = 1'b0;
	// Released line changes every cycle so no stale level is seen
	always @(posedge ref_clk) begin
		rel <= ~rel;
	end
	assign eeDo = !eeCs ? rel : (busy ? 1'b0 : drv);
	always @(posedge eeCs) begin
		cnt = 0;
		reading = 1'b0;
		drv = 1'b1;
	end
	always @(posedge eeSk) begin
		if (eeCs && !busy && (cnt > 0 || eeDi)) begin
			sr = {sr[23:0], eeDi};
			cnt++;
			if (cnt == 9 && sr[7:6] == OP_READ) begin
				rdAddr = sr[5:0];
				reading = 1'b1;
				drv = 1'b0;
			end else if (cnt == 9 && sr[7:6] == OP_MISC && sr[5:4] == 2'b11) begin
				wrEn = 1'b1;
			end else if (cnt == 9 && sr[7:6] == OP_MISC && sr[5:4] == 2'b00) begin
				wrEn = 1'b0;
			end else if (reading && cnt > 9 && cnt < 26) begin
				drv = mem[rdAddr[3:0]][25-cnt];
			end
		end
	end
	// programming cycle after a write command
	always @(negedge eeCs) begin
		if (cnt == 25 && !reading && sr[23:22] == OP_WRITE && wrEn) begin
			mem[sr[19:16]] = sr[15:0];
			busy = 1'b1;
			repeat (busyLen) @(posedge ref_clk);
			busy <= 1'b0;
		end
	end
endmodule

// ==== rcl_reset_config_loader_tb.sv ====
// Self-checking bench for the reset, strap and EEPROM loader
`define MEM i_rcl_eeprom_model.mem
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module rcl_reset_config_loader_tb
	import rcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POR_N  = 40;
	localparam int LOAD_N = 1280;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hostReset = 1'b0;
	logic [23:0] strapIn = '0;
	logic        eepromConfigSelect = 1'b0;
	logic        busWidthStrap = 1'b0;
	logic [7:0]  regAddr = '0;
	logic [7:0]  regWrData = '0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        strapPullDown, outputQuiesce, configCaptureWindow, accessBlocked, linkTestDisable;
	logic [7:0]  regRdData;
	logic        eeCs, eeSk, eeDi, eeDo;
	int          busyLen = 3;
	int          mismatches = 0;
	int          totalChecks = 0;
	logic [7:0]  expA, expB, expC, rdv, s, a, b, c;
	logic [23:0] straps;

	always #25 ref_clk = ~ref_clk;

	rcl_reset_config_loader #(.POR_CYCLES(POR_N), .LOAD_CYCLES(LOAD_N), .SK_HALF(2)) i_rcl_reset_config_loader (
		.ref_clk(ref_clk), .reset_n(reset_n), .hostReset(hostReset), .strapIn(strapIn),
		.eepromConfigSelect(eepromConfigSelect), .busWidthStrap(busWidthStrap),
		.strapPullDown(strapPullDown), .outputQuiesce(outputQuiesce),
		.configCaptureWindow(configCaptureWindow), .accessBlocked(accessBlocked),
		.linkTestDisable(linkTestDisable), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo));

	rcl_eeprom_model i_rcl_eeprom_model (
		.ref_clk(ref_clk), .busyLen(busyLen), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo));

	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		regAddr <= ad;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		regAddr <= ad;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
		@(posedge ref_clk);
	endtask

	task automatic chkRd(input logic [7:0] ad, input logic [7:0] e);
		logic [7:0] d;
		rd(ad, d);
		`CHK(d, e)
	endtask

	// Ends one nanosecond after the last edge that samples the pulse high
	task automatic hostPulse(input int n);
		hostReset <= 1'b1;
		repeat (n) @(posedge ref_clk);
		hostReset <= 1'b0;
		#1;
	endtask

	task automatic waitFree();
		int i;
		for (i = 0; i < LOAD_N && accessBlocked !== 1'b0; i++)
			@(posedge ref_clk) #1;
		`CHK(accessBlocked, 1'b0)
		@(posedge ref_clk);
	endtask

	function automatic int expSlot(input int k, input logic wide);
		return (k < IOM_WORDS) ? k : (wide ? 7 : 8);
	endfunction

	task automatic bootRun(input logic sel, input logic io, input logic wide);
		logic [15:0] w;
		straps = 24'($urandom);
		straps[CFGA_IOMODE_BIT] = io;
		straps[8+CFGB_STOREGO_BIT] = 1'b0;
		`MEM[14][CFGA_IOMODE_BIT] = io;
		`MEM[14][8+CFGB_STOREGO_BIT] = 1'b0;
		strapIn <= straps;
		eepromConfigSelect <= sel;
		busWidthStrap <= wide;
		{expC, expB, expA} = sel ? {`MEM[15][7:0], `MEM[14]} : straps;
		hostPulse(POR_N);
		`CHK(configCaptureWindow, 1'b1)
		`CHK(strapPullDown, 1'b1)
		@(posedge ref_clk);
		#1 `CHK(accessBlocked, 1'b1)
		@(posedge ref_clk);
		wr(ADDR_CFG_A, ~expA);
		chkRd(ADDR_CFG_A, 8'h00);
		waitFree();
		chkRd(ADDR_STATUS, {5'h00, wide, sel, 1'b0});
		chkRd(ADDR_CFG_A, expA);
		chkRd(ADDR_CFG_B, expB);
		chkRd(ADDR_CFG_C, expC);
		`CHK(linkTestDisable, expB[CFGB_LINKDIS_BIT])
		for (int k = 0; k < (io ? PROM_WORDS : SHM_WORDS); k++) begin
			rd(8'(ADDR_PROM + 2 * k), w[7:0]);
			rd(8'(ADDR_PROM + 2 * k + 1), w[15:8]);
			`CHK(w, `MEM[expSlot(k, wide)])
		end
		$display("test boot sel %0d io %0d wide %0d done", sel, io, wide);
	endtask

	initial begin
		void'($urandom(9));
		for (int k = 0; k < EE_WORDS; k++)
			`MEM[k] = 16'($urandom);
		`MEM[15][15:8] = 8'h73;
		s = 8'h00;
		for (int j = 0; j < 7; j++)
			s += `MEM[j/2][8*(j%2)+:8];
		`MEM[3][15:8] = 8'hFF - s;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		hostPulse(8);
		`CHK(outputQuiesce, 1'b0)
		@(posedge ref_clk);
		hostPulse(9);
		`CHK(outputQuiesce, 1'b1)
		`CHK(strapPullDown, 1'b1)
		repeat (2) @(posedge ref_clk);
		$display("test quiesce done");
		bootRun(1'b0, 1'b0, 1'b1);
		bootRun(1'b1, 1'b1, 1'b1);
		bootRun(1'b1, 1'b1, 1'b0);
		bootRun(1'b0, 1'b1, 1'b0);
		hostPulse(POR_N - 1);
		`CHK(configCaptureWindow, 1'b0)
		@(posedge ref_clk);
		waitFree();
		chkRd(ADDR_CFG_A, expA);
		chkRd(8'h05, 8'h00);
		$display("test short reset done");
		busyLen = 2 + ($urandom % 60);
		rd(ADDR_CFG_B, rdv);
		// keep only link bit, then set go
		b = (rdv & 8'h20) | 8'h10;
		a = 8'($urandom) & 8'h7F;
		c = 8'($urandom);
		wr(ADDR_CFG_B, b);
		chkRd(ADDR_CFG_B, b);
		wr(ADDR_CFG_B, a);
		@(posedge ref_clk);
		wr(ADDR_CFG_B, c);
		rdv = 8'h10;
		for (int i = 0; i < 3000 && rdv[CFGB_STOREGO_BIT] !== 1'b0; i++)
			rd(ADDR_CFG_B, rdv);
		`CHK(rdv[CFGB_STOREGO_BIT], 1'b0)
		`CHK(`MEM[14], {b & 8'hEF, a})
		`CHK(`MEM[15], {8'h73, c})
		$display("test write-back done");
		bootRun(1'b1, 1'b0, 1'b1);
		endSim();
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		endSim();
	end
endmodule
